// ### core/pin_remap_pkg.sv
// What this block does
// - timer route 00: trigger A12, channels A8-A11, break B12, complements B13-B15.
// - timer route 01: trigger/channels unchanged, break A6, complements A7, B0, B1.
// - timer route 11: all timer lines on port E; code 10 unused.
// - serial3 route 00: tx, rx, ck, cts, rts on B10 to B14.
// - serial3 route 01: tx, rx, ck on C10-C12; cts, rts stay B13, B14.
// - serial3 route 11: tx, rx, ck, cts, rts on D8-D12; code 10 unused.
// - bit 3: serial2 cts, rts, tx, rx, ck on A0-A4, else D3-D7.
// - bit 2: serial1 tx/rx on A9/A10, else B6/B7.
// - bit 1: two-wire clock/data on B6/B7, else B8/B9.
// - bit 0 clear: sperial1 lines on A4, A5, A6, A7, A2, A3.
// - bit 0 set: chip select A15, other sperial1 lines on B3-B7.
// - four 4-bit irq source fields, line n at bits 4n+3:4n.
// - irq line n takes pin n of port A..E for codes 0-4.
package pin_remap_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0] REMAP_LOW_OFFSET = 8'h04;
  localparam logic [7:0] EXTI_SS0_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_LEVEL_OFFSET = 8'h20;
  localparam int unsigned REMAP_LOW_W = 8;
  localparam int unsigned EXTI_SEL_W = 16;
  localparam logic [REMAP_LOW_W-1:0] REMAP_LOW_RESET = 8'h00;
  localparam logic [EXTI_SEL_W-1:0] EXTI_SS0_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int unsigned ADV_TIMER_LSB = 6;
  localparam int unsigned SERIAL3_LSB = 4;
  localparam int unsigned SERIAL2_BIT = 3;
  localparam int unsigned SERIAL1_BIT = 2;
  localparam int unsigned TWOWIRE1_BIT = 1;
  localparam int unsigned SPERIAL1_BIT = 0;
  localparam logic [1:0] ROUTE_DEFAULT = 2'h0;
  localparam logic [1:0] ROUTE_PARTIAL = 2'h1;
  localparam logic [1:0] ROUTE_UNUSED = 2'h2;
  localparam logic [1:0] ROUTE_FULL = 2'h3;
  localparam int unsigned IRQ_SEL_W = 4;
  localparam int unsigned NUM_IRQ = 4;
  localparam logic [IRQ_SEL_W-1:0] IRQ_SEL_MAX = 4'h4;

  // ---------------------------------------------------------------
  // ports and peripheral signal indices
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PORTS = 5;
  localparam int unsigned PINS_PER_PORT = 16;
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam int TMR_ETR = 0, TMR_CH0 = 1, TMR_CH1 = 2, TMR_CH2 = 3;
  localparam int TMR_CH3 = 4, TMR_BRK = 5;
  localparam int TMR_CN0 = 6, TMR_CN1 = 7, TMR_CN2 = 8;
  localparam int S3_TX = 9, S3_RX = 10, S3_CK = 11, S3_CTS = 12, S3_RTS = 13;
  localparam int S2_CTS = 14, S2_RTS = 15, S2_TX = 16, S2_RX = 17;
  localparam int S2_CK = 18, S1_TX = 19, S1_RX = 20;
  localparam int TW_SCL = 21, TW_SDA = 22;
  localparam int SP_NSS = 23, SP_SCK = 24, SP_MISO = 25, SP_MOSI = 26;
  localparam int SP_IO2 = 27, SP_IO3 = 28;
  localparam int NUM_SIG = 29;

  typedef logic [NUM_PORTS-1:0][PINS_PER_PORT-1:0] port_bank_t;
  typedef struct packed {
    logic [2:0] port;
    logic [3:0] pin;
  } pin_loc_s;
  typedef struct packed {
    logic o;
    logic oe;
  } pad_drive_s;

endpackage

// ### core/pin_crossbar.sv
`timescale 1ns/1ps
module pin_crossbar #(
  parameter int NUM_SIG = pin_remap_pkg::NUM_SIG
) (
  input wire pin_remap_pkg::pin_loc_s [NUM_SIG-1:0] sig_loc,
  input wire pin_remap_pkg::pad_drive_s [NUM_SIG-1:0] periph_drive,
  input wire pin_remap_pkg::port_bank_t pin_in,
  output logic [NUM_SIG-1:0] periph_in,
  output pin_remap_pkg::port_bank_t pin_out,
  output pin_remap_pkg::port_bank_t pin_oe
);
  import pin_remap_pkg::*;

  // ---------------------------------------------------------------
  // pin to peripheral
  // ---------------------------------------------------------------
  for (genvar s = 0; s < NUM_SIG; s++) begin : g_in
    wire valid_port = (sig_loc[s].port < PORT_E + 3'h1);
    assign periph_in[s] = valid_port ?
      pin_in[sig_loc[s].port][sig_loc[s].pin] : 1'b0;
  end

  // ---------------------------------------------------------------
  // peripheral to pin
  // ---------------------------------------------------------------
  // shared pins: lowest signal index that drives wins, no contention
  always_comb begin
    pin_out = '0;
    pin_oe = '0;
    for (int s = NUM_SIG - 1; s >= 0; s--) begin
      if (periph_drive[s].oe && sig_loc[s].port < PORT_E + 3'h1) begin
        pin_out[sig_loc[s].port][sig_loc[s].pin] = periph_drive[s].o;
        pin_oe[sig_loc[s].port][sig_loc[s].pin] = 1'b1;
      end
    end
  end

endmodule

// ### core/exti_line_select.sv
`timescale 1ns/1ps
module exti_line_select (
  input wire logic [pin_remap_pkg::EXTI_SEL_W-1:0] sel_word,
  input wire pin_remap_pkg::port_bank_t pin_in,
  output logic [pin_remap_pkg::NUM_IRQ-1:0] irq_line
);
  import pin_remap_pkg::*;

  // ---------------------------------------------------------------
  // per-line source mux
  // ---------------------------------------------------------------
  for (genvar n = 0; n < NUM_IRQ; n++) begin : g_line
    wire [IRQ_SEL_W-1:0] code = sel_word[n*IRQ_SEL_W +: IRQ_SEL_W];
    // reserved codes fall back to port a
    wire [2:0] port = (code <= IRQ_SEL_MAX) ? code[2:0] : PORT_A;
    assign irq_line[n] = pin_in[port][n];
  end

endmodule

// ### core/pin_remap_and_exti_select.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pin_remap_and_exti_select #(
  parameter int NUM_SIG = pin_remap_pkg::NUM_SIG
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pin_remap_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pin_remap_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pin_remap_pkg::port_bank_t pin_in,
  output pin_remap_pkg::port_bank_t pin_out,
  output pin_remap_pkg::port_bank_t pin_oe,
  input wire pin_remap_pkg::pad_drive_s [NUM_SIG-1:0] periph_drive,
  output logic [NUM_SIG-1:0] periph_in,
  output logic [pin_remap_pkg::NUM_IRQ-1:0] irq_line
);
  import pin_remap_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic pin_loc_s at(logic [2:0] port, logic [3:0] pin);
    pin_loc_s l;
    l.port = port;
    l.pin = pin;
    return l;
  endfunction

  // unused code 10 behaves as the default routing
  function automatic logic [1:0] eff_route(logic [1:0] code);
    return (code == ROUTE_UNUSED) ? ROUTE_DEFAULT : code;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old_v,
                                        logic [31:0] new_v,
                                        logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // route table
  // ---------------------------------------------------------------
  function automatic pin_loc_s loc_of(int sig, logic [7:0] rm);
    logic [1:0] tm;
    logic [1:0] s3;
    logic t_full;
    logic t_part;
    logic s3_full;
    logic s3_part;
    pin_loc_s l;
    tm = eff_route(rm[ADV_TIMER_LSB +: 2]);
    s3 = eff_route(rm[SERIAL3_LSB +: 2]);
    t_full = (tm == ROUTE_FULL);
    t_part = (tm == ROUTE_PARTIAL);
    s3_full = (s3 == ROUTE_FULL);
    s3_part = (s3 == ROUTE_PARTIAL);
    l = at(PORT_A, 4'h0);
    case (sig)
      TMR_ETR: l = t_full ? at(PORT_E, 4'h7) : at(PORT_A, 4'hc);
      TMR_CH0: l = t_full ? at(PORT_E, 4'h9) : at(PORT_A, 4'h8);
      TMR_CH1: l = t_full ? at(PORT_E, 4'hb) : at(PORT_A, 4'h9);
      TMR_CH2: l = t_full ? at(PORT_E, 4'hd) : at(PORT_A, 4'ha);
      TMR_CH3: l = t_full ? at(PORT_E, 4'he) : at(PORT_A, 4'hb);
      TMR_BRK: begin
        l = t_full ? at(PORT_E, 4'hf) :
            t_part ? at(PORT_A, 4'h6) : at(PORT_B, 4'hc);
      end
      TMR_CN0: begin
        l = t_full ? at(PORT_E, 4'h8) :
            t_part ? at(PORT_A, 4'h7) : at(PORT_B, 4'hd);
      end
      TMR_CN1: begin
        l = t_full ? at(PORT_E, 4'ha) :
            t_part ? at(PORT_B, 4'h0) : at(PORT_B, 4'he);
      end
      TMR_CN2: begin
        l = t_full ? at(PORT_E, 4'hc) :
            t_part ? at(PORT_B, 4'h1) : at(PORT_B, 4'hf);
      end
      S3_TX: begin
        l = s3_full ? at(PORT_D, 4'h8) :
            s3_part ? at(PORT_C, 4'ha) : at(PORT_B, 4'ha);
      end
      S3_RX: begin
        l = s3_full ? at(PORT_D, 4'h9) :
            s3_part ? at(PORT_C, 4'hb) : at(PORT_B, 4'hb);
      end
      S3_CK: begin
        l = s3_full ? at(PORT_D, 4'ha) :
            s3_part ? at(PORT_C, 4'hc) : at(PORT_B, 4'hc);
      end
      S3_CTS: l = s3_full ? at(PORT_D, 4'hb) : at(PORT_B, 4'hd);
      S3_RTS: l = s3_full ? at(PORT_D, 4'hc) : at(PORT_B, 4'he);
      S2_CTS: l = rm[SERIAL2_BIT] ? at(PORT_D, 4'h3) : at(PORT_A, 4'h0);
      S2_RTS: l = rm[SERIAL2_BIT] ? at(PORT_D, 4'h4) : at(PORT_A, 4'h1);
      S2_TX: l = rm[SERIAL2_BIT] ? at(PORT_D, 4'h5) : at(PORT_A, 4'h2);
      S2_RX: l = rm[SERIAL2_BIT] ? at(PORT_D, 4'h6) : at(PORT_A, 4'h3);
      S2_CK: l = rm[SERIAL2_BIT] ? at(PORT_D, 4'h7) : at(PORT_A, 4'h4);
      S1_TX: l = rm[SERIAL1_BIT] ? at(PORT_B, 4'h6) : at(PORT_A, 4'h9);
      S1_RX: l = rm[SERIAL1_BIT] ? at(PORT_B, 4'h7) : at(PORT_A, 4'ha);
      TW_SCL: l = rm[TWOWIRE1_BIT] ? at(PORT_B, 4'h8) : at(PORT_B, 4'h6);
      TW_SDA: l = rm[TWOWIRE1_BIT] ? at(PORT_B, 4'h9) : at(PORT_B, 4'h7);
      SP_NSS: l = rm[SPERIAL1_BIT] ? at(PORT_A, 4'hf) : at(PORT_A, 4'h4);
      SP_SCK: l = rm[SPERIAL1_BIT] ? at(PORT_B, 4'h3) : at(PORT_A, 4'h5);
      SP_MISO: l = rm[SPERIAL1_BIT] ? at(PORT_B, 4'h4) : at(PORT_A, 4'h6);
      SP_MOSI: l = rm[SPERIAL1_BIT] ? at(PORT_B, 4'h5) : at(PORT_A, 4'h7);
      SP_IO2: l = rm[SPERIAL1_BIT] ? at(PORT_B, 4'h6) : at(PORT_A, 4'h2);
      SP_IO3: l = rm[SPERIAL1_BIT] ? at(PORT_B, 4'h7) : at(PORT_A, 4'h3);
      default: l = at(PORT_A, 4'h0);
    endcase
    return l;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [REMAP_LOW_W-1:0] remap_low_r;
  logic [REMAP_LOW_W-1:0] remap_low_nxt;
  logic [EXTI_SEL_W-1:0] exti_sel_r;
  logic [EXTI_SEL_W-1:0] exti_sel_nxt;

  // ---------------------------------------------------------------
  // write channel state
  // ---------------------------------------------------------------
  logic aw_hold_r;
  logic [AXI_ADDR_W-1:0] aw_addr_r;
  logic w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  // write address and data may arrive in either order
  wire wr_fire = aw_hold_r && w_hold_r;
  wire [7:0] wr_word = {aw_addr_r[7:2], 2'h0};
  wire wr_hit_remap = (wr_word == REMAP_LOW_OFFSET);
  wire wr_hit_exti = (wr_word == EXTI_SS0_OFFSET);
  wire wr_ok = wr_hit_remap || wr_hit_exti;

  wire [31:0] remap_merged =
    merge({24'h0, remap_low_r}, w_data_r, w_strb_r);
  wire [31:0] exti_merged =
    merge({16'h0, exti_sel_r}, w_data_r, w_strb_r);

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // upper bits are not stored, so they are dropped on write
  assign remap_low_nxt = (wr_fire && wr_hit_remap) ?
    remap_merged[REMAP_LOW_W-1:0] : remap_low_r;
  // software keeps 31:16 at zero; the device ignores them
  assign exti_sel_nxt = (wr_fire && wr_hit_exti) ?
    exti_merged[EXTI_SEL_W-1:0] : exti_sel_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remap_low_r <= REMAP_LOW_RESET;
      exti_sel_r <= EXTI_SS0_RESET;
    end else begin
      remap_low_r <= remap_low_nxt;
      exti_sel_r <= exti_sel_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (aw_take) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (w_take) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] rd_word = {s_axi_araddr[7:2], 2'h0};
  wire rd_hit_remap = (rd_word == REMAP_LOW_OFFSET);
  wire rd_hit_exti = (rd_word == EXTI_SS0_OFFSET);
  wire rd_hit_level = (rd_word == IRQ_LEVEL_OFFSET);
  wire rd_ok = rd_hit_remap || rd_hit_exti || rd_hit_level;
  wire [31:0] rd_value =
    rd_hit_remap ? {24'h0, remap_low_r} :
    rd_hit_exti ? {16'h0, exti_sel_r} :
    rd_hit_level ? {28'h0, irq_line} : 32'h0;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_value;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin routing
  // ---------------------------------------------------------------
  // locations follow the registers with no pipeline stage, so a
  // route change is seen on the pins in the cycle after the write
  pin_loc_s [NUM_SIG-1:0] sig_loc;

  for (genvar s = 0; s < NUM_SIG; s++) begin : g_loc
    assign sig_loc[s] = loc_of(s, remap_low_r);
  end

  pin_crossbar #(
    .NUM_SIG(NUM_SIG)
  ) u_crossbar (
    .sig_loc(sig_loc),
    .periph_drive(periph_drive),
    .pin_in(pin_in),
    .periph_in(periph_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // ---------------------------------------------------------------
  // irq line sources
  // ---------------------------------------------------------------
  exti_line_select u_exti (
    .sel_word(exti_sel_r),
    .pin_in(pin_in),
    .irq_line(irq_line)
  );

endmodule

// ### tb/pin_remap_chk.sv
`timescale 1ns/1ps
module pin_remap_chk #(
  parameter int NUM_SIG = pin_remap_pkg::NUM_SIG
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pin_remap_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pin_remap_pkg::*;
  // ---------------------------------------------------------------
  // bus checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_tk = s_axi_awvalid && s_axi_awready;
  wire w_tk = s_axi_wvalid && s_axi_wready;
  wire ar_tk = s_axi_arvalid && s_axi_arready;
  wire [5:0] ar_w = s_axi_araddr[7:2];
  wire ar_remap = ar_w == REMAP_LOW_OFFSET[7:2];
  wire ar_sel = ar_w == EXTI_SS0_OFFSET[7:2];
  wire ar_map = ar_remap || ar_sel || ar_w == IRQ_LEVEL_OFFSET[7:2];

  AST_WR_RESP: assert property (
    aw_tk && w_tk |-> ##2 s_axi_bvalid) else $error("write answer missing");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_WR_BLOCK: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_RD_RESP: assert property (
    ar_tk |=> s_axi_rvalid) else $error("read answer missing");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while pending");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not retired");
  AST_RD_UNMAPPED: assert property (
    ar_tk && !ar_map |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_RD_REMAP_W: assert property (
    ar_tk && ar_remap |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 0)
    else $error("remap read wrong width or code");
  AST_RD_SEL_W: assert property (
    ar_tk && ar_sel |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:16] == 0)
    else $error("select read wrong width or code");
endmodule

bind pin_remap_and_exti_select pin_remap_chk #(.NUM_SIG(NUM_SIG)) u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ### tb/pad_world_model.sv
`timescale 1ns/1ps
module pad_world_model (
  input wire pin_remap_pkg::port_bank_t pin_out,
  input wire pin_remap_pkg::port_bank_t pin_oe,
  input wire pin_remap_pkg::port_bank_t ext_level,
  output pin_remap_pkg::port_bank_t pin_in
);
  import pin_remap_pkg::*;
  // driven pins read back their own drive, others show the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### tb/pin_remap_and_exti_select_tb.sv
`timescale 1ns/1ps
module pin_remap_and_exti_select_tb;
  import pin_remap_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [AXI_ADDR_W-1:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  port_bank_t ext = '0;
  port_bank_t pin_in, pin_out, pin_oe;
  pad_drive_s [NUM_SIG-1:0] drv = '0;
  logic [NUM_SIG-1:0] periph_in;
  logic [3:0] irq;
  int fails = 0, n_checks = 0, seed = 65855;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  // entry: remap byte, signal index, port, pin
  localparam logic [23:0] ROUTE_TAB [41] = '{
    24'h00000c, 24'h00051c, 24'h00081f,
    24'h40000c, 24'h400506, 24'h400607, 24'h400811,
    24'hc00047, 24'hc00149, 24'hc0044e, 24'hc0054f, 24'hc0074a,
    24'h80051c, 24'h20091a,
    24'h00091a, 24'h000d1e, 24'h10092a, 24'h100b2c, 24'h100c1d,
    24'h300938, 24'h300d3c,
    24'h000e00, 24'h001002, 24'h001204, 24'h080e33, 24'h081237,
    24'h001309, 24'h00140a, 24'h041316, 24'h041417,
    24'h001516, 24'h001617, 24'h021518, 24'h021619,
    24'h001704, 24'h001906, 24'h001b02, 24'h001c03,
    24'hff170f, 24'h011813, 24'h011c17
  };

  always #2 aclk = ~aclk;

  pin_remap_and_exti_select uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .periph_drive(drv), .periph_in(periph_in), .irq_line(irq)
  );
  pad_world_model world (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in)
  );

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t bresp %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t pin %b expected %b", $time, got, exp);
    end
  endtask

  always @(posedge aclk) begin
    if (rvalid && rready && exp_r.size() > 0)
      cmp_rd({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready && exp_b.size() > 0)
      cmp_b(bresp, exp_b.pop_front());
  end

  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    bit ad = 0, wd = 0;
    int i;
    exp_b.push_back(er);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready && !ad) begin ad = 1; awvalid <= 0; end
      if (wready && !wd) begin wd = 1; wvalid <= 0; end
      if (bvalid && ad && wd) break;
    end
    bready <= 0;
    if (i == 100) begin fails++; tally_and_finish(); end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    bit ad = 0;
    int i;
    exp_r.push_back(e);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready && !ad) begin ad = 1; arvalid <= 0; end
      else if (rvalid && ad) break;
    end
    rready <= 0;
    if (i == 100) begin fails++; tally_and_finish(); end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [23:0] e;
    logic [95:0] rnd;
    logic [3:0][3:0] sel;
    logic [3:0] ei;
    pad_drive_s [NUM_SIG-1:0] d;
    int p, q, sg, pt;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    axi_rd(REMAP_LOW_OFFSET, {RESP_OKAY, 32'h0});
    axi_rd(EXTI_SS0_OFFSET, {RESP_OKAY, 32'h0});
    $display("test reset values done");
    axi_rd(8'h10, {RESP_SLVERR, 32'h0});
    axi_wr(8'h0c, 32'h1, 4'hf, RESP_SLVERR);
    axi_wr(IRQ_LEVEL_OFFSET, 32'h1, 4'hf, RESP_SLVERR);
    axi_wr(EXTI_SS0_OFFSET, 32'h3412, 4'h1, RESP_OKAY);
    axi_rd(EXTI_SS0_OFFSET, {RESP_OKAY, 32'h12});
    $display("test bus refusals done");
    foreach (ROUTE_TAB[k]) begin
      e = ROUTE_TAB[k];
      sg = e[15:8]; p = e[7:4]; q = e[3:0];
      axi_wr(REMAP_LOW_OFFSET, {24'h0, e[23:16]}, 4'hf, RESP_OKAY);
      rnd = {$random(seed), $random(seed), $random(seed)};
      d = '0;
      d[sg].o = rnd[80];
      d[sg].oe = 1'b1;
      drv <= d;
      ext <= rnd[79:0];
      @(posedge aclk);
      cmp_pin(pin_oe[p][q], 1'b1);
      cmp_pin(pin_out[p][q], rnd[80]);
      drv <= '0;
      @(posedge aclk);
      cmp_pin(periph_in[sg], ext[p][q]);
      cmp_pin(|pin_oe, 1'b0);
    end
    $display("test routing done");
    for (int k = 0; k < 8; k++) begin
      for (int n = 0; n < 4; n++)
        sel[n] = k < 5 ? 4'((k + n) % 5) : k == 5 ? 4'h9 : k == 6 ? 4'hf :
                 4'($unsigned($random(seed)) % 5);
      rnd = {$random(seed), $random(seed), $random(seed)};
      ext <= rnd[79:0];
      for (int n = 0; n < 4; n++) begin
        pt = sel[n] > IRQ_SEL_MAX ? 0 : int'(sel[n]);
        ei[n] = rnd[pt * 16 + n];
      end
      axi_wr(EXTI_SS0_OFFSET, {16'h0, sel}, 4'hf, RESP_OKAY);
      @(posedge aclk);
      for (int n = 0; n < 4; n++)
        cmp_pin(irq[n], ei[n]);
      axi_rd(IRQ_LEVEL_OFFSET, {RESP_OKAY, 28'h0, ei});
      axi_rd(EXTI_SS0_OFFSET, {RESP_OKAY, 16'h0, sel});
    end
    $display("test irq select done");
    tally_and_finish();
  end
endmodule
